// ### hw/mirl_top.v
`timescale 1ns/1ps
`default_nettype none
module mirl_top (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // external request pins
  input  wire        ext_req_primary_n,
  input  wire        ext_req_secondary,
  // timer and core
  input  wire        timer_zero,
  input  wire        software_trap,
  input  wire        core_mask,
  input  wire        core_ack,
  input  wire        return_from_trap,
  // outputs to core and timer
  output reg         irq_q,
  output reg  [2:0]  irq_src_q,
  output reg  [11:0] vector_q,
  output reg         accept_busy_q,
  output reg         prescaler_clear,
  output reg         ext1_level_q,
  output reg         ext2_level_q
);
  `include "mirl_defines.vh"

  // apb transfer strobes
  wire apb_acc = psel & penable;
  wire wr_en   = apb_acc & pwrite;

  wire        ext1_lvl;
  wire        ext1_fall;
  wire        ext2_lvl;
  wire        ext2_fall;
  reg         timer_req_flag;
  reg         timer_req_mask;
  reg         ext2_req_flag;
  reg         ext2_req_mask;
  reg         ext1_pend_q;
  reg         trap_pend_q;
  reg         rst_pend_q;
  reg         in_service_q;
  reg  [3:0]  accept_cnt_q;
  wire [2:0]  win_src;
  wire [11:0] win_vec;

  ////////////////////////////////////////////////////////////////////////////
  // addressed-register test, shared by write and read decode
  function hit;
    input [11:0] a;
    input [11:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin conditioning
  mirl_edge_det u_ext1 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (ext_req_primary_n),
    .level_q (ext1_lvl),
    .fall_q  (ext1_fall)
  );

  mirl_edge_det u_ext2 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (ext_req_secondary),
    .level_q (ext2_lvl),
    .fall_q  (ext2_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin levels as plain inputs
  // secondary level readable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext1_level_q <= 1'b1;
      ext2_level_q <= 1'b1;
    end else begin
      ext1_level_q <= ext1_lvl;
      ext2_level_q <= ext2_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer control: flag and mask; set beats a same-cycle clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_req_flag <= 1'b0;
      timer_req_mask <= 1'b1;
    end else begin
      if (wr_en && hit(paddr, `MIRL_TCR_ADDR)) begin
        timer_req_mask <= pwdata[`MIRL_MASK_BIT];
        if (!pwdata[`MIRL_FLAG_BIT])
          timer_req_flag <= 1'b0;
      end
      if (timer_zero)
        timer_req_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler clear pulse, never stored for readback
  // write one clears
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prescaler_clear <= 1'b0;
    else
      prescaler_clear <= wr_en & hit(paddr, `MIRL_TCR_ADDR) & pwdata[`MIRL_PCLR_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // misc register: secondary flag and mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext2_req_flag <= 1'b0;
      ext2_req_mask <= 1'b1;
    end else begin
      if (wr_en && hit(paddr, `MIRL_MISC_ADDR)) begin
        ext2_req_mask <= pwdata[`MIRL_MASK_BIT];
        if (!pwdata[`MIRL_FLAG_BIT])
          ext2_req_flag <= 1'b0;
      end
      if (ext2_fall)
        ext2_req_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched primary, trap and reset requests; cleared when the core takes them
  // held while masked
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext1_pend_q <= 1'b0;
      trap_pend_q <= 1'b0;
      rst_pend_q  <= 1'b1;
    end else begin
      if (core_ack && irq_q && irq_src_q == `MIRL_SRC_EXT1)
        ext1_pend_q <= 1'b0;
      if (core_ack && irq_q && irq_src_q == `MIRL_SRC_TRAP)
        trap_pend_q <= 1'b0;
      if (core_ack && irq_q && irq_src_q == `MIRL_SRC_RESET)
        rst_pend_q <= 1'b0;
      if (ext1_fall)
        ext1_pend_q <= 1'b1;
      if (software_trap)
        trap_pend_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration; shared source is the or of two unmasked flags
  // one shared vector
  mirl_prio u_prio (
    .core_mask  (core_mask),
    .rst_req    (rst_pend_q),
    .trap_req   (trap_pend_q),
    .ext1_req   (ext1_pend_q),
    .shared_req ((timer_req_flag & ~timer_req_mask) | (ext2_req_flag & ~ext2_req_mask)),
    .src        (win_src),
    .vec        (win_vec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // acceptance sequence: 11 cycles of stacking and vector fetch,
  // then in service until return; a new request waits for the window, and for return unless it is reset or core mask is clear
  // eleven cycle accept
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_cnt_q  <= 4'h0;
      accept_busy_q <= 1'b0;
      in_service_q  <= 1'b0;
    end else begin
      if (accept_cnt_q != 4'h0) begin
        accept_cnt_q  <= accept_cnt_q - 4'h1;
        accept_busy_q <= (accept_cnt_q != 4'h1);
      end else if (core_ack && irq_q) begin
        accept_cnt_q  <= `MIRL_ACCEPT_CYC - 4'h1;
        accept_busy_q <= 1'b1;
        in_service_q  <= 1'b1;
      end
      if (return_from_trap)
        in_service_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request presented to the core; dropped while accepting
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q     <= 1'b0;
      irq_src_q <= `MIRL_SRC_NONE;
      vector_q  <= `MIRL_VEC_RESET;
    end else begin
      irq_q     <= (win_src != `MIRL_SRC_NONE) && !accept_busy_q && !(core_ack && irq_q)
                   && (!in_service_q || win_src == `MIRL_SRC_RESET || core_mask == 1'b0);
      irq_src_q <= win_src;
      vector_q  <= win_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, error on unmapped or write to read-only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (hit(paddr, `MIRL_TCR_ADDR)) begin
          prdata[7:0] <= {timer_req_flag, timer_req_mask, 6'h00} | `MIRL_TCR_ONES;
        end else if (hit(paddr, `MIRL_MISC_ADDR)) begin
          prdata[7:0] <= {ext2_req_flag, ext2_req_mask, 6'h00} | `MIRL_MISC_ONES;
        end else if (hit(paddr, `MIRL_STAT_ADDR)) begin
          prdata[7:0] <= {accept_busy_q, in_service_q, rst_pend_q, trap_pend_q,
                          ext1_pend_q, irq_q, ext2_lvl, ext1_lvl};
          pslverr     <= pwrite;
        end else if (hit(paddr, `MIRL_VEC_ADDR)) begin
          prdata[11:0] <= vector_q;
          pslverr      <= pwrite;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/mirl_defines.vh
// Behaviour
// - With core mask set: reset, then trap; primary and timer/secondary are not presented.
// - With core mask clear: primary second, timer/secondary third, trap lowest.
// - Vectors FFE/FFF reset, FFC/FFD trap, FFA/FFB primary, FF8/FF9 shared.
// - Requests arriving while masked stay pending until the mask clears.
// - Timer and secondary share one vector; software reads both flags.
// - Software clears timer and secondary flags by writing 0; 1 leaves them.
// - External requests register only on a high-to-low pin transition.
// - Secondary flag at misc bit 7, its mask at misc bit 6.
// - Secondary mask set blocks its interrupt; the flag still sets.
// - Secondary pin level always readable as a plain input bit.
// - Set timer or secondary flag interrupts the core when core mask clear.
// - Timer flag, control bit 7, sets at count zero; reset clears it.
// - Timer mask, control bit 6, blocks timer interrupt; reset sets it.
// - Writing 1 to control bit 3 clears the prescaler; it reads 0.
// - Timer control bits 5, 4, 2, 1, 0 read as 1.
// - Secondary flag sets on a falling pin edge; reset clears it.
// - Misc register bits 5 to 0 read as 1.
// - Software trap is taken regardless of core mask.
// - Primary pin level readable for bit-test branches.
// - Accepting an interrupt stacks state, sets mask, fetches vector: 11 cycles.
`ifndef MIRL_DEFINES_VH
`define MIRL_DEFINES_VH
// register byte addresses
`define MIRL_TCR_ADDR     12'h000
`define MIRL_MISC_ADDR    12'h004
`define MIRL_STAT_ADDR    12'h008
`define MIRL_VEC_ADDR     12'h00C
// field positions
`define MIRL_FLAG_BIT     7
`define MIRL_MASK_BIT     6
`define MIRL_PCLR_BIT     3
// fixed read patterns of unused bits
`define MIRL_TCR_ONES     8'h37
`define MIRL_MISC_ONES    8'h3F
// vector addresses (high byte of each pair)
`define MIRL_VEC_RESET    12'hFFE
`define MIRL_VEC_TRAP     12'hFFC
`define MIRL_VEC_EXT1     12'hFFA
`define MIRL_VEC_SHARED   12'hFF8
// source codes
`define MIRL_SRC_NONE     3'h0
`define MIRL_SRC_RESET    3'h1
`define MIRL_SRC_TRAP     3'h2
`define MIRL_SRC_EXT1     3'h3
`define MIRL_SRC_SHARED   3'h4
// acceptance sequence length in cycles
`define MIRL_ACCEPT_CYC   4'hB
`endif

// ### hw/mirl_edge_det.v
`timescale 1ns/1ps
`default_nettype none
module mirl_edge_det (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // pin and results
  input  wire pin_in,
  output reg  level_q,
  output reg  fall_q
);
  reg meta_q;
  reg prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // idle pins are high, so sync chain resets high to avoid a false edge
  // sync and compare
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q  <= 1'b1;
      level_q <= 1'b1;
      prev_q  <= 1'b1;
      fall_q  <= 1'b0;
    end else begin
      meta_q  <= pin_in;
      level_q <= meta_q;
      prev_q  <= level_q;
      fall_q  <= prev_q & ~level_q;
    end
  end
endmodule
`default_nettype wire

// ### hw/mirl_prio.v
`timescale 1ns/1ps
`default_nettype none
module mirl_prio (
  // requests
  input  wire       core_mask,
  input  wire       rst_req,
  input  wire       trap_req,
  input  wire       ext1_req,
  input  wire       shared_req,
  // winner
  output reg  [2:0] src,
  output reg  [11:0] vec
);
  `include "mirl_defines.vh"

  ////////////////////////////////////////////////////////////////////////////
  // the trap is an instruction, so with mask clear it only waits its turn
  // vector per source
  always @* begin
    src = `MIRL_SRC_NONE;
    vec = `MIRL_VEC_RESET;
    if (rst_req) begin
      src = `MIRL_SRC_RESET;
      vec = `MIRL_VEC_RESET;
    end else if (core_mask) begin
      if (trap_req) begin
        src = `MIRL_SRC_TRAP;
        vec = `MIRL_VEC_TRAP;
      end
    end else if (ext1_req) begin
      src = `MIRL_SRC_EXT1;
      vec = `MIRL_VEC_EXT1;
    end else if (shared_req) begin
      src = `MIRL_SRC_SHARED;
      vec = `MIRL_VEC_SHARED;
    end else if (trap_req) begin
      src = `MIRL_SRC_TRAP;
      vec = `MIRL_VEC_TRAP;
    end
  end
endmodule
`default_nettype wire

// ### verif/mirl_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module mirl_core_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // design side
  input  wire logic       irq_q,
  input  wire logic       accept_busy_q,
  output logic            core_ack,
  output logic            return_from_trap,
  output logic            core_mask,
  // bench controls
  input  wire logic       mask_req,
  input  wire logic [1:0] lag
);
  logic       ack_q, ret_q, svc_q;
  logic [1:0] cnt_q;
  ////////////////////////////////////////////////////////////
  // mask while serving
  assign core_mask        = mask_req | svc_q;
  assign core_ack         = ack_q;
  assign return_from_trap = ret_q;
  // lag lets the core answer promptly or slowly
  // ack then return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ack_q, ret_q, svc_q, cnt_q} <= '0;
    end else begin
      ack_q <= 1'b0;
      ret_q <= 1'b0;
      if (ack_q) begin
        svc_q <= 1'b1;
      end else if (svc_q ? !accept_busy_q : irq_q) begin
        cnt_q <= cnt_q + 2'h1;
        if (cnt_q == lag) begin
          cnt_q <= 2'h0;
          ack_q <= !svc_q;
          ret_q <= svc_q;
          svc_q <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/mirl_chk_props.sv
`timescale 1ns/1ps
`default_nettype none
module mirl_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // bus and pins
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        ext_req_primary_n,
  input wire logic        ext_req_secondary,
  // core side
  input wire logic        core_mask,
  input wire logic        core_ack,
  input wire logic        irq_q,
  input wire logic [2:0]  irq_src_q,
  input wire logic [11:0] vector_q,
  input wire logic        accept_busy_q,
  input wire logic        prescaler_clear,
  input wire logic        ext1_level_q,
  input wire logic        ext2_level_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  // vectors follow the presented source
  chk_vec_trap: assert property (irq_q && irq_src_q == 3'h2 |-> vector_q == 12'hFFC)
    else $error("trap vector wrong");
  chk_vec_ext1: assert property (irq_q && irq_src_q == 3'h3 |-> vector_q == 12'hFFA)
    else $error("primary vector wrong");
  chk_vec_shared: assert property (irq_q && irq_src_q == 3'h4 |-> vector_q == 12'hFF8)
    else $error("shared vector wrong");
  // acceptance drops the request and runs the stacking window
  chk_ack_drop: assert property (irq_q && core_ack |=> !irq_q && accept_busy_q)
    else $error("ack not taken");
  chk_accept_len: assert property ($rose(accept_busy_q) |->
      accept_busy_q[*8] ##1 accept_busy_q ##1 accept_busy_q ##1 !accept_busy_q)
    else $error("accept window length wrong");
  // with the core masked only reset or trap may be newly presented
  chk_masked_rank: assert property ($rose(irq_q) && $past(core_mask) && core_mask |->
      irq_src_q inside {3'h1, 3'h2})
    else $error("masked request presented");
  chk_pclr_pulse: assert property (prescaler_clear ==
      $past(psel && penable && pwrite && paddr == 12'h000 && pwdata[3]))
    else $error("prescaler clear pulse wrong");
  // synchronised levels settle within the sync depth
  chk_ext1_level: assert property ($stable(ext_req_primary_n)[*5] |->
      ext1_level_q == ext_req_primary_n)
    else $error("primary level wrong");
  chk_ext2_level: assert property ($stable(ext_req_secondary)[*5] |->
      ext2_level_q == ext_req_secondary)
    else $error("secondary level wrong");
endmodule
bind mirl_top mirl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .ext_req_primary_n, .ext_req_secondary, .core_mask, .core_ack, .irq_q, .irq_src_q,
  .vector_q, .accept_busy_q, .prescaler_clear, .ext1_level_q, .ext2_level_q);
`default_nettype wire

// ### verif/tb_mcu_interrupt_request_logic.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_interrupt_request_logic;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, vector_q;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq_q, accept_busy_q, core_ack, return_from_trap, core_mask;
  logic        ext_req_primary_n = 1'b1, ext_req_secondary = 1'b1, timer_zero = 1'b0;
  logic        software_trap = 1'b0, mask_req = 1'b1, prescaler_clear, ext1_level_q, ext2_level_q;
  logic [1:0]  lag = 2'h0;
  logic [2:0]  irq_src_q;
  logic [33:0] rq[$];
  logic [14:0] vq[$];
  int          fails = 0, n_tests = 0;
  ////////////////////////////////////////////////////////////
  always #25 pclk = ~pclk;
  mirl_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_req_primary_n, .ext_req_secondary, .timer_zero, .software_trap, .core_mask,
    .core_ack, .return_from_trap, .irq_q, .irq_src_q, .vector_q, .accept_busy_q,
    .prescaler_clear, .ext1_level_q, .ext2_level_q);
  mirl_core_model u_core (.pclk, .presetn, .irq_q, .accept_busy_q, .core_ack,
    .return_from_trap, .core_mask, .mask_req, .lag);
  task automatic wrap_up();
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic bad(input string m);
    fails++;
    $display("Error %0t %s", $time, m);
  endtask
  task automatic chk_rd(input logic [33:0] e);
    n_tests++;
    if (pslverr !== e[32] || (!e[33] && prdata !== e[31:0])) bad("apb answer differs");
  endtask
  task automatic chk_vec(input logic [14:0] e);
    n_tests++;
    if ({irq_src_q, vector_q} !== e) bad("source or vector differs");
  endtask
  // one apb transfer; for a read d is the expected data
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
    rq.push_back({w, err, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // let the core take one interrupt, unmasking it first if asked
  task automatic take(input logic [2:0] s, input logic [11:0] v, input logic um);
    vq.push_back({s, v});
    lag <= 2'($urandom);
    if (um) mask_req <= 1'b0;
    do @(posedge pclk); while (core_ack !== 1'b1);
    mask_req <= 1'b1;
    do @(posedge pclk); while (return_from_trap !== 1'b1);
  endtask
  // an answer with no note left is itself a fault
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (rq.size() == 0) bad("unexpected apb answer");
      else chk_rd(rq.pop_front());
    end
    if (irq_q && core_ack) begin
      if (vq.size() == 0) bad("unexpected interrupt");
      else chk_vec(vq.pop_front());
    end
  end
  // cuts a hang short
  initial begin
    #1000000;
    fails++;
    wrap_up();
  end
  initial begin
    void'($urandom(30948));
    vq.push_back({3'h1, 12'hFFE});
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    do @(posedge pclk); while (return_from_trap !== 1'b1);
    xfer(0, 12'h000, 32'h77, 0);
    xfer(0, 12'h004, 32'h7F, 0);
    xfer(1, 12'h010, $urandom, 1);
    xfer(1, 12'h008, $urandom, 1);
    xfer(1, 12'h000, 32'h08, 0);
    xfer(0, 12'h000, 32'h37, 0);
    @(posedge pclk) timer_zero <= 1'b1;
    @(posedge pclk) timer_zero <= 1'b0;
    repeat (6) @(posedge pclk);
    xfer(0, 12'h000, 32'hB7, 0);
    take(3'h4, 12'hFF8, 1);
    xfer(1, 12'h000, ($urandom & 32'hFFFFFF3F) | 32'h80, 0);
    xfer(0, 12'h000, 32'hB7, 0);
    xfer(1, 12'h000, 32'h40, 0);
    xfer(0, 12'h000, 32'h77, 0);
    xfer(1, 12'h004, 32'h00, 0);
    @(posedge pclk) ext_req_secondary <= 1'b0;
    repeat (6) @(posedge pclk);
    xfer(0, 12'h004, 32'hBF, 0);
    take(3'h4, 12'hFF8, 1);
    xfer(1, 12'h004, 32'h00, 0);
    xfer(0, 12'h004, 32'h3F, 0);
    @(posedge pclk) ext_req_secondary <= 1'b1;
    repeat (6) @(posedge pclk);
    xfer(0, 12'h004, 32'h3F, 0);
    xfer(1, 12'h004, 32'h40, 0);
    @(posedge pclk) ext_req_secondary <= 1'b0;
    repeat (6) @(posedge pclk);
    xfer(0, 12'h004, 32'hFF, 0);
    mask_req <= 1'b0;
    repeat (20) @(posedge pclk);
    mask_req <= 1'b1;
    xfer(1, 12'h004, 32'h40, 0);
    xfer(0, 12'h004, 32'h7F, 0);
    xfer(1, 12'h000, 32'h00, 0);
    @(posedge pclk);
    ext_req_primary_n <= 1'b0;
    timer_zero <= 1'b1;
    software_trap <= 1'b1;
    @(posedge pclk);
    timer_zero <= 1'b0;
    software_trap <= 1'b0;
    take(3'h2, 12'hFFC, 0);
    take(3'h3, 12'hFFA, 1);
    take(3'h4, 12'hFF8, 1);
    ext_req_primary_n <= 1'b1;
    repeat (6) @(posedge pclk);
    wrap_up();
  end
endmodule
`default_nettype wire
